// *** verilog/sar_adc_timing_result_regs.v ***
// Purpose: Converter mode, resolution and result registers with the conversion sequencer
// Assumes: One CPU byte access per cycle; approximation value supplied by the analog side
// Notes: Word reads of the result use the even address and return all 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defines.vh"
// Functional notes
// - Short-sample off: 21 clocks, 9 sampling, divide 8/4/2/1
// - Short-sample on: 15 clocks, 3 sampling
// - Resolution bit0: 0 ten-bit, 1 eight-bit
// - Results reload from approximation at conversion end
// - Word result left-justified, low six bits zero
// - Upper byte high address, low bits 7:6
// - Word result read-only, read as 16 bits
// - Eight-bit mode clears two lowest result bits
// - Byte result holds result bits nine to two
// - Byte result read-only, single byte read
// - Conversion end pulse when result latched
// - Run bit clears itself at conversion end
module sar_adc_timing_result_regs (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   input wire clkEn,
   // CPU register access
   input wire [19:0] addr,
   input wire wrEn,
   input wire rdEn,
   input wire wordAccess,
   input wire [7:0] wrData,
   output reg [15:0] rdData,
   // Analog front end
   input wire [9:0] approxValue,
   output reg sampling,
   output reg comparing,
   output reg comparatorOn,
   output reg eightBitMode,
   output reg [3:0] channelSel,
   // Events
   output reg conversionDoneIrq
);
   // Sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_COMPARE = 2'h2;

   reg [7:0] mode0_q;
   reg [7:0] mode0_d;
   reg resSel_q;
   reg [3:0] chSel_q;
   reg [15:0] resultWord_q;
   reg [1:0] state_q;
   reg [4:0] clkCount_q;
   reg startPend_q;
   reg [15:0] readNext;
   wire divTick;
   wire [1:0] lowBits;
   wire runBit = mode0_q[`M0_RUN];
   // Lengths count conversion clocks from the first divided tick
   wire [4:0] sampleLen = mode0_q[`M0_SAMPLE] ? `SAMPLE_SHORT : `SAMPLE_LONG;
   wire [4:0] totalLen = mode0_q[`M0_SAMPLE] ? `TOTAL_SHORT : `TOTAL_LONG;
   wire selMode0 = addr == `OFF_MODE0;
   wire wrMode0 = wrEn && selMode0;
   // Run only sets when the comparator is already enabled, since the
   // comparator needs time to settle before its first conversion
   wire runSet = wrMode0 && wrData[`M0_RUN] && !runBit && mode0_q[`M0_CMP_EN];
   // The counter holds the number of the conversion clock now running
   wire lastClk = divTick && state_q == ST_COMPARE && clkCount_q == totalLen;

   // Eight-bit mode zeroes the two lowest bits when the result is latched
   genvar bitIdx;
   generate
      for (bitIdx = 0; bitIdx < 2; bitIdx = bitIdx + 1) begin : lowBitGen
         assign lowBits[bitIdx] = approxValue[bitIdx] & ~resSel_q;
      end
   endgenerate

   conv_clock_div divider (
      .core_clk(core_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .restart(runSet),
      .divSel(mode0_q[`M0_DIV_HI:`M0_DIV_LO]),
      .tick(divTick)
   );

   // Next mode value; the hardware clear of the run bit is folded in here so
   // a write and the end of a conversion never fight over the same flop
   always @* begin
      mode0_d = mode0_q;
      if (wrMode0) begin
         mode0_d = wrData & `M0_MASK;
         // A rewrite of 1 while running stops rather than restarts
         mode0_d[`M0_RUN] = runSet && wrData[`M0_CMP_EN];
      end
      if (lastClk && runBit) begin
         mode0_d[`M0_RUN] = 1'b0;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode0_q <= `RESET_BYTE;
         resultWord_q <= `RESET_WORD;
         state_q <= ST_IDLE;
         clkCount_q <= 5'h00;
         startPend_q <= 1'b0;
         conversionDoneIrq <= 1'b0;
      end else if (clkEn) begin
         conversionDoneIrq <= 1'b0;
         mode0_q <= mode0_d;
         if (runSet) begin
            startPend_q <= 1'b1;
            state_q <= ST_IDLE;
         end else if (!runBit || (wrMode0 && !wrData[`M0_RUN])) begin
            // Software stop aborts without touching the results
            state_q <= ST_IDLE;
            startPend_q <= 1'b0;
         end else if (divTick) begin
            case (state_q)
               ST_IDLE: begin
                  // Sampling opens on the first tick of the restarted divider
                  if (startPend_q) begin
                     startPend_q <= 1'b0;
                     state_q <= ST_SAMPLE;
                     clkCount_q <= 5'h01;
                  end
               end
               ST_SAMPLE: begin
                  clkCount_q <= clkCount_q + 5'h01;
                  if (clkCount_q == sampleLen) begin
                     state_q <= ST_COMPARE;
                  end
               end
               ST_COMPARE: begin
                  clkCount_q <= clkCount_q + 5'h01;
                  if (lastClk) begin
                     resultWord_q <= {approxValue[9:2], lowBits, 6'h00};
                     conversionDoneIrq <= 1'b1;
                     state_q <= ST_IDLE;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Resolution and channel stores; the sequencer only reads them
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         resSel_q <= 1'b0;
         chSel_q <= 4'h0;
      end else if (clkEn) begin
         if (wrEn && addr == `OFF_RESCTL) begin
            resSel_q <= wrData[`RES_SEL];
         end
         // Channel is plain storage; the analog multiplexer decodes it
         if (wrEn && addr == `OFF_CHSEL) begin
            chSel_q <= wrData[`CH_SEL_HI:0];
         end
      end
   end

   // Read selection; unmapped addresses return zero
   always @* begin
      readNext = 16'h0000;
      case (addr)
         `OFF_RESULT_LO: begin
            readNext = wordAccess ? resultWord_q : {8'h00, resultWord_q[7:0]};
         end
         `OFF_RESULT_HI: begin
            readNext = {8'h00, resultWord_q[15:8]};
         end
         `OFF_RESCTL: begin
            readNext = {15'h0000, resSel_q};
         end
         `OFF_MODE0: begin
            readNext = {8'h00, mode0_q};
         end
         `OFF_CHSEL: begin
            readNext = {12'h000, chSel_q};
         end
         default: begin
            readNext = 16'h0000;
         end
      endcase
   end

   // Registered read path; result registers ignore writes
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdData <= 16'h0000;
         sampling <= 1'b0;
         comparing <= 1'b0;
         comparatorOn <= 1'b0;
         eightBitMode <= 1'b0;
         channelSel <= 4'h0;
      end else if (clkEn) begin
         // Status levels lag the sequencer state by one cycle
         sampling <= state_q == ST_SAMPLE;
         comparing <= state_q == ST_COMPARE;
         comparatorOn <= mode0_q[`M0_CMP_EN];
         eightBitMode <= resSel_q;
         channelSel <= chSel_q;
         if (rdEn) begin
            rdData <= readNext;
         end else begin
            rdData <= 16'h0000;
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/sar_adc_defines.vh ***
// Purpose: Constants for the converter timing and result register block
// Assumes: Peripheral clock of 100 MHz, byte-addressed CPU register access
// Notes: Offsets are byte addresses on the CPU's internal peripheral bus
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH
`define ADDR_W 20
`define OFF_MODE0 20'hfff30
`define OFF_RESCTL 20'hf0010
`define OFF_RESULT_LO 20'hfff1e
`define OFF_RESULT_HI 20'hfff1f
`define OFF_CHSEL 20'hfff31
// Mode register 0, resolution and channel fields; reset values
`define M0_RUN 7
`define M0_DIV_HI 5
`define M0_DIV_LO 4
`define M0_SAMPLE 3
`define M0_CMP_EN 0
`define M0_MASK 8'hb9
`define RES_SEL 0
`define CH_SEL_HI 3
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
// Conversion lengths in conversion clocks
`define SAMPLE_LONG 5'h09
`define TOTAL_LONG 5'h15
`define SAMPLE_SHORT 5'h03
`define TOTAL_SHORT 5'h0f
`endif

// *** verilog/conv_clock_div.v ***
// Purpose: Conversion clock enable divider (by 8, 4, 2 or 1)
// Assumes: Restart aligns the phase to the first divided tick
// Notes: Produces a one-cycle tick per conversion clock
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   input wire clkEn,
   // Control
   input wire restart,
   input wire [1:0] divSel,
   // Output
   output reg tick
);
   reg [2:0] cnt_q;
   reg [2:0] lastCount;
   always @* begin
      case (divSel)
         2'h0: lastCount = 3'h7;
         2'h1: lastCount = 3'h3;
         2'h2: lastCount = 3'h1;
         default: lastCount = 3'h0;
      endcase
   end
   // Restarting keeps every conversion exactly N divided clocks
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 3'h0;
         tick <= 1'b0;
      end else if (clkEn) begin
         if (restart) begin
            cnt_q <= 3'h0;
            tick <= 1'b0;
         end else if (cnt_q >= lastCount) begin
            cnt_q <= 3'h0;
            tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 3'h1;
            tick <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/sar_adc_chk.sv ***
// Purpose: Assertions on converter phases and result reads
// Assumes: Sees only the block's top ports
// Notes: Phase lengths rebuilt from mode writes
`timescale 1ns/1ps
`default_nettype none
module sar_adc_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   // Register access
   input wire logic [19:0] addr,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic wordAccess,
   input wire logic [7:0] wrData,
   input wire logic [15:0] rdData,
   // Status
   input wire logic sampling,
   input wire logic comparing,
   input wire logic eightBitMode,
   input wire logic conversionDoneIrq
);
   logic [2:0] mode_q;
   logic [7:0] samp_q;
   logic [7:0] comp_q;
   logic [7:0] fac;
   assign fac = 8'h08 >> mode_q[2:1];
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= 3'h0;
         samp_q <= 8'h00;
         comp_q <= 8'h00;
      end else if (clkEn) begin
         if (wrEn && addr == 20'hfff30) mode_q <= wrData[5:3];
         samp_q <= sampling ? samp_q + 8'h01 : 8'h00;
         comp_q <= comparing ? comp_q + 8'h01 : 8'h00;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_sampLen; $fell(sampling) |-> samp_q == (mode_q[0] ? 8'h03 : 8'h09) * fac; endproperty
   a_sampLen: assert property (p_sampLen) else $error("sample length");
   property p_compLen; $fell(comparing) |-> comp_q == 8'h0c * fac; endproperty
   a_compLen: assert property (p_compLen) else $error("compare length");
   property p_order; $rose(comparing) |-> $past(sampling); endproperty
   a_order: assert property (p_order) else $error("compare without sample");
   property p_excl; !(sampling && comparing); endproperty
   a_excl: assert property (p_excl) else $error("phases overlap");
   property p_irqPulse; conversionDoneIrq |=> !conversionDoneIrq; endproperty
   a_irqPulse: assert property (p_irqPulse) else $error("done pulse too long");
   property p_irqEnd; conversionDoneIrq |-> $past(comparing) || $past(comparing, 2); endproperty
   a_irqEnd: assert property (p_irqEnd) else $error("done without compare");
   property p_wordLow;
      $past(clkEn && rdEn && wordAccess && addr == 20'hfff1e) |-> rdData[5:0] == 6'h00;
   endproperty
   a_wordLow: assert property (p_wordLow) else $error("word low bits set");
   property p_resWr;
      $changed(eightBitMode) |-> $past(wrEn && addr == 20'hf0010) || $past(wrEn && addr == 20'hf0010, 2);
   endproperty
   a_resWr: assert property (p_resWr) else $error("resolution moved");
endmodule
`default_nettype wire

// *** verif/sar_front_model.sv ***
// Purpose: Front end holding the sampled level
// Assumes: Level is held from sampling to end of conversion
// Notes: Unknown until the first sampling phase
`timescale 1ns/1ps
`default_nettype none
module sar_front_model (
   // Clock and phase
   input wire logic core_clk,
   input wire logic sampling,
   // Level in, approximation out
   input wire logic [9:0] level,
   output logic [9:0] approxValue
);
   always @(posedge core_clk) begin
      if (sampling) approxValue <= level;
   end
endmodule
`default_nettype wire

// *** verif/tb_sar_adc_timing_result_regs.sv ***
// Purpose: Bench for converter timing and result registers
// Assumes: Byte results appear on rdData[7:0]
// Notes: Clock enable is dropped once, outside any conversion
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_timing_result_regs;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic clkEn = 1'b1;
   logic [19:0] addr = 20'h0;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic wordAccess = 1'b0;
   logic [7:0] wrData = 8'h00;
   logic [9:0] level = 10'h000;
   wire [9:0] approxValue;
   wire [15:0] rdData;
   wire sampling, comparing, comparatorOn, eightBitMode, conversionDoneIrq;
   wire [3:0] channelSel;
   int errCount = 0;
   int comparisons = 0;
   logic [15:0] q;
   always #5 core_clk = ~core_clk;
   sar_adc_timing_result_regs dut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .addr(addr),
      .wrEn(wrEn), .rdEn(rdEn), .wordAccess(wordAccess), .wrData(wrData), .rdData(rdData),
      .approxValue(approxValue), .sampling(sampling), .comparing(comparing),
      .comparatorOn(comparatorOn), .eightBitMode(eightBitMode), .channelSel(channelSel),
      .conversionDoneIrq(conversionDoneIrq));
   sar_front_model fe (.core_clk(core_clk), .sampling(sampling), .level(level),
      .approxValue(approxValue));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(negedge core_clk);
      addr = a;
      wrData = d;
      wrEn = 1'b1;
      @(negedge core_clk);
      wrEn = 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, input logic w);
      @(negedge core_clk);
      addr = a;
      wordAccess = w;
      rdEn = 1'b1;
      @(negedge core_clk);
      q = rdData;
      rdEn = 1'b0;
   endtask
   task automatic summarize;
      $display("comparisons %0d errCount %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Fully stop, set resolution, set timing, then run alone
   task automatic conv(input logic e, input logic [1:0] dv, input logic lv, input logic [9:0] v);
      int n;
      level = v;
      wr(20'hfff30, 8'h00);
      wr(20'hf0010, {7'h7f, e});
      wr(20'hfff30, {2'h0, dv, lv, 3'h1});
      wr(20'hfff30, {2'h2, dv, lv, 3'h1});
      n = 0;
      while (conversionDoneIrq !== 1'b1) begin
         @(negedge core_clk);
         n++;
         if (n > 2000) begin
            errCount++;
            summarize();
         end
      end
      rd(20'hfff30, 1'b0);
      check("mode0", q[7:0], {2'h0, dv, lv, 3'h1});
      rd(20'hfff1e, 1'b1);
      check("word", q, {v[9:2], e ? 2'h0 : v[1:0], 6'h00});
      rd(20'hfff1f, 1'b0);
      check("high", q[7:0], v[9:2]);
      rd(20'hf0010, 1'b0);
      check("res", q[7:0], {7'h00, e});
      check("flags", {eightBitMode, comparatorOn}, {e, 1'b1});
   endtask
   // Result registers ignore writes; unmapped reads return zero
   task automatic readonly_regs;
      wr(20'hfff1e, 8'hff);
      wr(20'hfff1f, 8'hff);
      rd(20'hfff1e, 1'b1);
      check("word reset", q, 16'h0000);
      rd(20'hfff1f, 1'b0);
      check("high reset", q, 16'h0000);
      rd(20'h00100, 1'b0);
      check("unmapped", q, 16'h0000);
   endtask
   // Channel store, then a write made while the clock enable is low is lost
   task automatic channel_freeze;
      wr(20'hfff31, 8'h02);
      @(negedge core_clk);
      check("chan", {12'h000, channelSel}, 16'h0002);
      clkEn = 1'b0;
      wr(20'hfff31, 8'h05);
      @(negedge core_clk);
      clkEn = 1'b1;
      @(negedge core_clk);
      check("frozen", {12'h000, channelSel}, 16'h0002);
      rd(20'hfff31, 1'b0);
      check("chan reg", q, 16'h0002);
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      rstn = 1'b1;
      readonly_regs();
      channel_freeze();
      for (int i = 0; i < 8; i++) begin
         conv(i[0], i[1:0], i[2], 10'h3c7 ^ {i[4:0], i[4:0]});
      end
      summarize();
   end
endmodule
bind sar_adc_timing_result_regs sar_adc_chk chk (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
   .addr(addr), .wrEn(wrEn), .rdEn(rdEn), .wordAccess(wordAccess), .wrData(wrData),
   .rdData(rdData), .sampling(sampling), .comparing(comparing), .eightBitMode(eightBitMode),
   .conversionDoneIrq(conversionDoneIrq));
`default_nettype wire
